// file: verilog/sfbfe_pkg.sv
// Shared constants and types of the serial flash bus front end
package sfbfe_pkg;

    localparam int SFBFE_LANES = 4;
    localparam int LANE_ZERO = 0;
    localparam int LANE_ONE = 1;
    localparam int LANE_THREE = 3;

    // Bits gathered per byte and bits moved per edge
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] STEP_WIDE = 4'h4;
    localparam logic [3:0] STEP_NARROW = 4'h1;

    // Output enable patterns
    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_WIDE = 4'hF;

    // Reset values of the pin synchronisers: {clock, select_n, reset_n, lanes}
    localparam logic [6:0] SAMPLE_IDLE = 7'h3F;
    localparam logic SCLK_IDLE = 1'h0;
    localparam logic SELECT_IDLE = 1'h1;

    typedef enum logic [3:0]
    {
        SFBFE_IDLE = 4'h1,
        SFBFE_CMD = 4'h2,
        SFBFE_RECV = 4'h4,
        SFBFE_SEND = 4'h8
    } sfbfe_state_t;

endpackage

// file: verilog/sfbfe_pin_if.sv
// Synchronised pin levels and edge pulses from the sampler to the front end
interface sfbfe_pin_if;
    logic sclkRise;
    logic sclkFall;
    logic selectN;
    logic selectFall;
    logic resetPinN;
    logic [3:0] lanes;

    modport sampler
    (
        output sclkRise,
        output sclkFall,
        output selectN,
        output selectFall,
        output resetPinN,
        output lanes
    );

    modport front
    (
        input sclkRise,
        input sclkFall,
        input selectN,
        input selectFall,
        input resetPinN,
        input lanes
    );
endinterface

// file: verilog/sfbfe_pin_sampler.sv
// Two-stage synchronisers and edge finders for the flash bus pins
module sfbfe_pin_sampler
    import sfbfe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic selectPinN,
    input wire logic resetPinN,
    input wire logic [3:0] laneIn,
    sfbfe_pin_if.sampler pins
);

    typedef struct packed {
        logic [6:0] stage1;
        logic [6:0] stage2;
        logic sclkPrev;
        logic selectPrev;
    } sfbfe_sample_t;

    sfbfe_sample_t cur;
    sfbfe_sample_t next_cur;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cur = cur;
        next_cur.stage1 = {serialClk, selectPinN, resetPinN, laneIn};
        next_cur.stage2 = cur.stage1;
        // Edge history reads the second stage only
        next_cur.sclkPrev = cur.stage2[6];
        next_cur.selectPrev = cur.stage2[5];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '{SAMPLE_IDLE, SAMPLE_IDLE, SCLK_IDLE, SELECT_IDLE};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign pins.sclkRise = cur.stage2[6] & ~cur.sclkPrev;
    assign pins.sclkFall = ~cur.stage2[6] & cur.sclkPrev;
    assign pins.selectN = cur.stage2[5];
    assign pins.selectFall = cur.selectPrev & ~cur.stage2[5];
    assign pins.resetPinN = cur.stage2[4];
    assign pins.lanes = cur.stage2[3:0];

endmodule // sfbfe_pin_sampler

// file: verilog/sfbfe_front_end.sv
// Serial flash bus front end: select, standby, edge sampling and pin reset
module sfbfe_front_end
    import sfbfe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic selectPinN,
    input wire logic resetPinN,
    input wire logic [3:0] laneIn,
    output logic [3:0] laneOut,
    output logic [3:0] laneOe,
    input wire logic dedicatedResetPin,
    input wire logic resetDisableNonvol,
    input wire logic resetDisableVolatile,
    input wire logic fourLaneProtocol,
    input wire logic quadCommand,
    input wire logic doubleRate,
    input wire logic coreBusy,
    input wire logic coreTurnOut,
    input wire logic [7:0] coreTxByte,
    output logic rxCmdValid,
    output logic [7:0] rxCmd,
    output logic rxDataValid,
    output logic [7:0] rxData,
    output logic txTake,
    output logic standby,
    output logic active,
    output logic armed,
    output logic inReset
);

    typedef struct packed {
        sfbfe_state_t state;
        logic armed;
        logic [3:0] bitCount;
        logic [7:0] shift;
        logic [7:0] txShift;
        logic rxCmdValid;
        logic [7:0] rxCmd;
        logic rxDataValid;
        logic [7:0] rxData;
        logic txTake;
        logic [3:0] laneOut;
        logic [3:0] laneOe;
        logic standby;
        logic active;
        logic inReset;
    } sfbfe_front_t;

    sfbfe_front_t cur;
    sfbfe_front_t next_cur;

    sfbfe_pin_if pins();

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling
    ////////////////////////////////////////////////////////////////////////
    sfbfe_pin_sampler u_sampler
    (
        .clk(clk),
        .rst(rst),
        .serialClk(serialClk),
        .selectPinN(selectPinN),
        .resetPinN(resetPinN),
        .laneIn(laneIn),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    ////////////////////////////////////////////////////////////////////////
    // Gathers one edge worth of bits, most significant bit first
    function automatic logic [7:0] sfbfe_gather
    (
        input logic [7:0] acc,
        input logic [3:0] lanes,
        input logic wide
    );
        if (wide)
        begin
            return {acc[3:0], lanes};
        end
        return {acc[6:0], lanes[LANE_ZERO]};
    endfunction

    function automatic logic [3:0] sfbfe_step(input logic wide);
        return wide ? STEP_WIDE : STEP_NARROW;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    ////////////////////////////////////////////////////////////////////////
    logic wideData;
    logic inEdge;
    logic outEdge;
    logic resetEnabled;
    logic laneThreeIsData;
    logic dedicatedHit;
    logic sharedHit;
    logic hwReset;
    logic [3:0] cmdCount;
    logic [3:0] dataCount;

    always_comb
    begin
        wideData = fourLaneProtocol | quadCommand;
        // A byte always starts on a rising edge, so the falling half of
        // the last command clock is not taken as data in double rate
        inEdge = pins.sclkRise
            | (doubleRate & pins.sclkFall & (cur.bitCount != 4'h0));
        outEdge = pins.sclkFall | (doubleRate & pins.sclkRise);
        resetEnabled = ~(resetDisableNonvol | resetDisableVolatile);
        // Lane three is payload in four-lane protocol and in quad phases
        laneThreeIsData = fourLaneProtocol
            | (quadCommand
               & ((cur.state == SFBFE_RECV) | (cur.state == SFBFE_SEND)));
        dedicatedHit = dedicatedResetPin & ~pins.resetPinN;
        // The shared lane only counts while selected; the host keeps it
        // high through single commands, so a low here is a real reset
        sharedHit = ~dedicatedResetPin & ~pins.selectN
            & ~laneThreeIsData & ~pins.lanes[LANE_THREE];
        hwReset = resetEnabled & (dedicatedHit | sharedHit);
        cmdCount = cur.bitCount + sfbfe_step(fourLaneProtocol);
        dataCount = cur.bitCount + sfbfe_step(wideData);

        next_cur = cur;
        next_cur.rxCmdValid = 1'h0;
        next_cur.rxDataValid = 1'h0;
        next_cur.txTake = 1'h0;
        // A running program or erase finishes before standby
        next_cur.standby = pins.selectN & ~coreBusy;
        next_cur.active = ~pins.selectN;
        next_cur.inReset = hwReset;

        if (hwReset)
        begin
            // Core busy is not protected: aborting it may lose data
            next_cur.state = SFBFE_IDLE;
            next_cur.armed = 1'h0;
            next_cur.bitCount = '0;
            next_cur.laneOe = OE_NONE;
        end
        else if (pins.selectN)
        begin
            next_cur.state = SFBFE_IDLE;
            next_cur.bitCount = '0;
            next_cur.laneOe = OE_NONE;
        end
        else
        begin
            case (cur.state)
                SFBFE_IDLE:
                begin
                    // Select already low at pin reset release is not a start
                    if (pins.selectFall)
                    begin
                        next_cur.armed = 1'h1;
                        next_cur.state = SFBFE_CMD;
                        next_cur.bitCount = '0;
                        next_cur.shift = '0;
                    end
                end
                SFBFE_CMD:
                begin
                    if (pins.sclkRise)
                    begin
                        next_cur.shift = sfbfe_gather(cur.shift,
                            pins.lanes, fourLaneProtocol);
                        next_cur.bitCount = cmdCount;
                        if (cmdCount == BYTE_BITS)
                        begin
                            next_cur.rxCmd = sfbfe_gather(cur.shift,
                                pins.lanes, fourLaneProtocol);
                            next_cur.rxCmdValid = cur.armed;
                            next_cur.state = SFBFE_RECV;
                            next_cur.bitCount = '0;
                        end
                    end
                end
                SFBFE_RECV:
                begin
                    if (coreTurnOut)
                    begin
                        next_cur.txShift = coreTxByte;
                        next_cur.txTake = 1'h1;
                        next_cur.state = SFBFE_SEND;
                        next_cur.bitCount = '0;
                    end
                    else if (inEdge)
                    begin
                        // Bytes go to the core one byte at a time; this
                        // path carries program data, never a page erase
                        next_cur.shift = sfbfe_gather(cur.shift,
                            pins.lanes, wideData);
                        next_cur.bitCount = dataCount;
                        if (dataCount == BYTE_BITS)
                        begin
                            next_cur.rxData = sfbfe_gather(cur.shift,
                                pins.lanes, wideData);
                            next_cur.rxDataValid = 1'h1;
                            next_cur.bitCount = '0;
                        end
                    end
                end
                SFBFE_SEND:
                begin
                    if (outEdge)
                    begin
                        if (wideData)
                        begin
                            next_cur.laneOut = cur.txShift[7:4];
                            next_cur.laneOe = OE_WIDE;
                            next_cur.txShift = {cur.txShift[3:0], 4'h0};
                        end
                        else
                        begin
                            next_cur.laneOut = {2'h0, cur.txShift[7],
                                1'h0};
                            next_cur.laneOe = OE_SINGLE;
                            next_cur.txShift = {cur.txShift[6:0], 1'h0};
                        end
                        next_cur.bitCount = dataCount;
                        if (dataCount == BYTE_BITS)
                        begin
                            // Core must hold its next byte ready
                            next_cur.txShift = coreTxByte;
                            next_cur.txTake = 1'h1;
                            next_cur.bitCount = '0;
                        end
                    end
                end
                default:
                begin
                    next_cur.state = SFBFE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur <= '{state: SFBFE_IDLE, default: '0};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////
    assign laneOut = cur.laneOut;
    assign laneOe = cur.laneOe;
    assign rxCmdValid = cur.rxCmdValid;
    assign rxCmd = cur.rxCmd;
    assign rxDataValid = cur.rxDataValid;
    assign rxData = cur.rxData;
    assign txTake = cur.txTake;
    assign standby = cur.standby;
    assign active = cur.active;
    assign armed = cur.armed;
    assign inReset = cur.inReset;

endmodule // sfbfe_front_end

// file: bench/sfbfe_props.sv
// Port-level checker of the serial flash bus front end
module sfbfe_props
    import sfbfe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic selectPinN,
    input wire logic resetPinN,
    input wire logic [3:0] laneOe,
    input wire logic dedicatedResetPin,
    input wire logic resetDisableNonvol,
    input wire logic resetDisableVolatile,
    input wire logic fourLaneProtocol,
    input wire logic quadCommand,
    input wire logic coreBusy,
    input wire logic rxCmdValid,
    input wire logic standby,
    input wire logic active,
    input wire logic armed,
    input wire logic inReset
);
    timeunit 1ns;
    timeprecision 100ps;

    logic hwOn;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Six cycles covers the pin synchronisers plus the output register
    assign hwOn = !resetDisableNonvol && !resetDisableVolatile;
    sequence deselHeld;
        selectPinN [*6];
    endsequence
    sequence selHeld;
        !selectPinN [*6];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    chk_oe_released:
    assert property (deselHeld |-> laneOe == OE_NONE)
        else $error("lanes driven while deselected");
    chk_desel_no_cmd:
    assert property (deselHeld |-> !rxCmdValid)
        else $error("command taken while deselected");
    chk_cmd_armed:
    assert property (rxCmdValid |-> armed)
        else $error("command taken before select fall");
    chk_arm_on_fall:
    assert property ($fell(selectPinN) && resetPinN |-> ##[1:6] armed)
        else $error("select fall not seen");
    chk_busy_no_standby:
    assert property (coreBusy [*2] |-> !standby)
        else $error("standby while core busy");
    chk_standby_idle:
    assert property ((deselHeld and !coreBusy [*6]) |-> standby)
        else $error("no standby when deselected and idle");
    chk_active_sel:
    assert property (selHeld |-> active)
        else $error("not active while selected");
    chk_reset_quiet:
    assert property (inReset [*2] |-> laneOe == OE_NONE && !armed)
        else $error("outputs or arming kept during reset");
    chk_disable_reset:
    assert property (!hwOn [*6] |-> !inReset)
        else $error("reset applied while disabled");
    chk_dedicated_pin:
    assert property ((dedicatedResetPin && hwOn && !resetPinN) [*6]
        |-> inReset)
        else $error("dedicated reset pin ignored");
    chk_shared_quad:
    assert property ((!dedicatedResetPin && fourLaneProtocol) [*6]
        |-> !inReset)
        else $error("shared reset taken in four-lane protocol");
    chk_single_lanes:
    assert property ((!fourLaneProtocol && !quadCommand) [*8]
        |-> laneOe != OE_WIDE)
        else $error("all lanes driven in single-lane command");
endmodule // sfbfe_props

bind sfbfe_front_end sfbfe_props u_props (.clk(clk), .rst(rst),
    .selectPinN(selectPinN), .resetPinN(resetPinN), .laneOe(laneOe),
    .dedicatedResetPin(dedicatedResetPin),
    .resetDisableNonvol(resetDisableNonvol),
    .resetDisableVolatile(resetDisableVolatile),
    .fourLaneProtocol(fourLaneProtocol), .quadCommand(quadCommand),
    .coreBusy(coreBusy), .rxCmdValid(rxCmdValid), .standby(standby),
    .active(active), .armed(armed), .inReset(inReset));

// file: bench/sfbfe_host_model.sv
// Behavioural host controller driving the flash bus pins
module sfbfe_host_model
(
    output logic serialClk,
    output logic selectPinN,
    output logic [3:0] hostLanes,
    input wire logic [3:0] busLanes
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock stands still low outside frames
    initial
    begin
        serialClk = 1'b0;
        selectPinN = 1'b1;
        hostLanes = 4'hF;
    end

    task automatic sel(input logic v);
        if (v)
            hostLanes[2:0] = ~hostLanes[2:0]; // Released lines do not hold
        selectPinN = v;
        #80;
    endtask

    task automatic lane3(input logic v);
        hostLanes[3] = v;
    endtask

    // Double rate: even steps on rising, odd steps on falling edges
    task automatic send(input logic [7:0] b, input logic wide,
        input logic ddr);
        logic [7:0] s;
        s = b;
        for (int i = 0; i < (wide ? 2 : 8); i++)
        begin
            hostLanes = wide ? s[7:4] : {3'h7, s[7]};
            s = wide ? s << 4 : s << 1;
            #30;
            serialClk = !ddr || !i[0];
            #40;
            if (!ddr)
                serialClk = 1'b0;
            #10;
        end
    endtask

    // Samples late in the low phase, well after the falling-edge update
    task automatic recv(output logic [7:0] b, input logic wide);
        b = 8'h00;
        for (int i = 0; i < (wide ? 2 : 8); i++)
        begin
            serialClk = 1'b1;
            #40;
            serialClk = 1'b0;
            #70;
            b = wide ? {b[3:0], busLanes} : {b[6:0], busLanes[1]};
            #10;
        end
    endtask
endmodule // sfbfe_host_model

// file: bench/sfbfe_front_end_tb_top.sv
// Self-checking testbench of the serial flash bus front end
module sfbfe_front_end_tb_top
    import sfbfe_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic resetPinN, dedicatedResetPin, resetDisableNonvol;
    logic resetDisableVolatile, fourLaneProtocol, quadCommand, doubleRate;
    logic coreBusy, coreTurnOut, serialClk, selectPinN, rxCmdValid;
    logic rxDataValid, txTake, standby, active, armed, inReset;
    logic [7:0] coreTxByte, rxCmd, rxData, b;
    logic [3:0] laneOut, laneOe, laneIn, hostLanes;
    int n_fail, checks_done, nCmd, nData, nTake, cyc;
    logic [1:0] rowMode [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
    logic rowDdr [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] rowCmd [4] = '{8'h9F, 8'hEB, 8'h0B, 8'h6B};
    logic [7:0] rowData [4] = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};

    ////////////////////////////////////////////////////////////////////////
    // Wire level of each lane: device when enabled, host otherwise
    assign laneIn = (laneOe & laneOut) | (~laneOe & hostLanes);
    always #5 clk = ~clk;

    sfbfe_host_model u_host (.serialClk(serialClk), .selectPinN(selectPinN),
        .hostLanes(hostLanes), .busLanes(laneIn));

    sfbfe_front_end u_dut (.clk(clk), .rst(rst), .serialClk(serialClk),
        .selectPinN(selectPinN), .resetPinN(resetPinN), .laneIn(laneIn),
        .laneOut(laneOut), .laneOe(laneOe),
        .dedicatedResetPin(dedicatedResetPin),
        .resetDisableNonvol(resetDisableNonvol),
        .resetDisableVolatile(resetDisableVolatile),
        .fourLaneProtocol(fourLaneProtocol), .quadCommand(quadCommand),
        .doubleRate(doubleRate), .coreBusy(coreBusy),
        .coreTurnOut(coreTurnOut), .coreTxByte(coreTxByte),
        .rxCmdValid(rxCmdValid), .rxCmd(rxCmd), .rxDataValid(rxDataValid),
        .rxData(rxData), .txTake(txTake), .standby(standby),
        .active(active), .armed(armed), .inReset(inReset));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Pulses are counted so that none is missed between comparisons
    always @(posedge clk)
    begin
        cyc++;
        nCmd += int'(rxCmdValid === 1'b1);
        nData += int'(rxDataValid === 1'b1);
        nTake += int'(txTake === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        resetPinN = 1'b1;
        dedicatedResetPin = 1'b1;
        resetDisableNonvol = 1'b0;
        resetDisableVolatile = 1'b0;
        fourLaneProtocol = 1'b0;
        quadCommand = 1'b0;
        doubleRate = 1'b0;
        coreBusy = 1'b0;
        coreTurnOut = 1'b0;
        coreTxByte = 8'h00;
        tick(2);
        rst = 1'b0;
        check("laneOe", 8'(laneOe), 8'h00);
        u_host.send(8'hA5, 1'b0, 1'b0);
        tick(10);
        check("cmdCount", 8'(nCmd), 8'h00);
        check("armed", 8'(armed), 8'h00);
        for (int r = 0; r < 4; r++)
        begin
            tick(1);
            quadCommand = rowMode[r][1];
            fourLaneProtocol = rowMode[r][0];
            doubleRate = rowDdr[r];
            u_host.sel(1'b0);
            check("active", 8'(active), 8'h01);
            u_host.send(rowCmd[r], rowMode[r][0], 1'b0);
            tick(10);
            check("rxCmd", rxCmd, rowCmd[r]);
            u_host.send(rowData[r], |rowMode[r], rowDdr[r]);
            tick(10);
            check("rxData", rxData, rowData[r]);
            check("dataCount", 8'(nData), 8'(r + 1));
            u_host.sel(1'b1);
            check("laneOe", 8'(laneOe), 8'h00);
        end
        // Hand-written: reads in single and quad width
        for (int w = 0; w < 2; w++)
        begin
            tick(1);
            quadCommand = w[0];
            fourLaneProtocol = 1'b0;
            doubleRate = 1'b0;
            u_host.sel(1'b0);
            u_host.send(8'h6B, 1'b0, 1'b0);
            tick(10);
            coreTxByte = rowData[w];
            coreTurnOut = 1'b1;
            tick(1);
            coreTurnOut = 1'b0;
            tick(4);
            u_host.recv(b, w[0]);
            check("txByte", b, rowData[w]);
            check("laneOe", 8'(laneOe), w[0] ? 8'h0F : 8'h02);
            check("takeCount", 8'(nTake), 8'(2 * w + 2));
            u_host.sel(1'b1);
        end
        tick(1);
        coreBusy = 1'b1;
        tick(8);
        check("standby", 8'(standby), 8'h00);
        coreBusy = 1'b0;
        tick(8);
        check("standby", 8'(standby), 8'h01);
        resetPinN = 1'b0;
        tick(8);
        check("inReset", 8'(inReset), 8'h01);
        resetPinN = 1'b1;
        for (int k = 1; k < 3; k++)
        begin
            tick(8);
            resetDisableNonvol = k[1];
            resetDisableVolatile = k[0];
            resetPinN = 1'b0;
            tick(8);
            check("inReset", 8'(inReset), 8'h00);
            resetPinN = 1'b1;
            resetDisableNonvol = 1'b0;
            resetDisableVolatile = 1'b0;
        end
        // Reset in mid-select: no command until a fresh select fall
        u_host.sel(1'b0);
        tick(1);
        resetPinN = 1'b0;
        tick(8);
        check("armed", 8'(armed), 8'h00);
        resetPinN = 1'b1;
        tick(8);
        u_host.send(8'h9F, 1'b0, 1'b0);
        tick(10);
        check("cmdCount", 8'(nCmd), 8'h06);
        u_host.sel(1'b1);
        tick(1);
        dedicatedResetPin = 1'b0;
        fourLaneProtocol = 1'b1;
        u_host.sel(1'b0);
        u_host.lane3(1'b0);
        tick(8);
        check("inReset", 8'(inReset), 8'h00);
        fourLaneProtocol = 1'b0;
        tick(8);
        check("inReset", 8'(inReset), 8'h01);
        u_host.lane3(1'b1);
        u_host.sel(1'b1);
        conclude();
    end
endmodule // sfbfe_front_end_tb_top
